/* File: include/dma_front_pkg.sv */
// Constants and types shared by the cascaded DMA register front
package dma_front_pkg;
   localparam int GROUPS = 2;
   localparam int CHANS = 4;
   localparam int BYTE_GROUP = 0;
   localparam int WORD_GROUP = 1;
   // I/O base of each group; unused, since the top level takes group selects on i_group_sel
   localparam logic [11:0] BYTE_GROUP_BASE = 12'h000;
   localparam logic [11:0] WORD_GROUP_BASE = 12'h0c0;
   // Register index within a group after the address lines are decoded
   localparam logic [3:0] IDX_STATUS = 4'h8;
   localparam logic [3:0] IDX_REQUEST = 4'h9;
   localparam logic [3:0] IDX_SINGLE_MASK = 4'ha;
   localparam logic [3:0] IDX_MODE = 4'hb;
   localparam logic [3:0] IDX_POINTER = 4'hc;
   localparam logic [3:0] IDX_TEMP_CLEAR = 4'hd;
   localparam logic [3:0] IDX_CLEAR_MASK = 4'he;
   localparam logic [3:0] IDX_ALL_MASK = 4'hf;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [7:0] TEMP_VALUE = 8'h00;
   localparam logic [5:0] MODE_RESET = 6'h00;
   localparam logic [3:0] MASK_RESET = 4'hf;
   localparam logic [3:0] SWREQ_RESET = 4'h0;
   localparam logic [1:0] MODE_CNT_RESET = 2'h0;
   localparam logic POINTER_RESET = 1'b0;
   localparam int CMD_DISABLE_BIT = 2;
   // Synchroniser bundle: rd_n, wr_n, sel[1:0], hold, xa[4:0], data, req
   localparam int SYNC_W = 25;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 25'h1800000;
   typedef enum logic [1:0] {COND_IDLE, COND_PROGRAM, COND_ACTIVE} cond_t;
endpackage

/* File: include/dma_cond_if.sv */
`timescale 1ns/1ps
// Signals between the register front and one group's condition tracker
interface dma_cond_if;
   import dma_front_pkg::*;
   logic cpu_access;
   logic request;
   logic enabled;
   cond_t cond;
   modport tracker (input cpu_access, input request, input enabled,
      output cond);
   modport front (output cpu_access, output request, output enabled,
      input cond);
endinterface // dma_cond_if

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
// Two flip-flop synchroniser for the pin inputs
module pin_sync
   import dma_front_pkg::*;
#(
   parameter int W = SYNC_W
) (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   always_comb begin
      next_meta = i_async;
      next_sync = meta;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         meta <= SYNC_RESET[W-1:0];
         o_sync <= SYNC_RESET[W-1:0];
      end else begin
         meta <= next_meta;
         o_sync <= next_sync;
      end
   end
endmodule // pin_sync

/* File: verilog/dma_condition_tracker.sv */
`timescale 1ns/1ps
// Idle, program and active condition of one controller group
module dma_condition_tracker
   import dma_front_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   dma_cond_if.tracker bus
);
   cond_t state;
   cond_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         COND_IDLE: begin
            // A CPU cycle already under way goes first
            if (bus.cpu_access) begin
               next_state = COND_PROGRAM;
            end else if (bus.enabled && bus.request) begin
               next_state = COND_ACTIVE;
            end
         end
         COND_PROGRAM: begin
            if (!bus.cpu_access) begin
               next_state = COND_IDLE;
            end
         end
         COND_ACTIVE: begin
            if (!(bus.enabled && bus.request)) begin
               next_state = COND_IDLE;
            end
         end
         default: begin
            next_state = COND_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         state <= COND_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign bus.cond = state;
endmodule // dma_condition_tracker

/* File: verilog/cascaded_dma_register_front.sv */
`timescale 1ns/1ps
// Register front and operating conditions of the cascaded DMA subsystem
// Summary of operation
// - Four byte channels and three word channels from two cascaded groups.
// - Word group channel 0 carries the byte group's hold request.
// - Address registers: write loads base and current, read current byte.
// - Count registers: write loads base and current, read current byte.
// - Request register is readable and writable in each group.
// - Single mask port write sets or clears one mask bit; read gives command.
// - Clear port write clears all masks; read clears mode counter.
// - All-mask port reads and writes every mask bit at once.
// - Idle condition drives no transfer activity.
// - Active only when enabled and an unmasked request is present.
// - A CPU register access moves an idle group to program condition.
// - Byte pointer cleared by reset or master clear, set or cleared by port.
// - Word group decodes address bits 1 to 4, byte group bits 0 to 3.
// - Program condition wins over active when both arrive together.
module cascaded_dma_register_front
   import dma_front_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_io_read_strobe_n,
   input wire logic i_io_write_strobe_n,
   input wire logic [1:0] i_group_sel,
   input wire logic i_hold_ack,
   input wire logic [4:0] i_register_select_lines,
   input wire logic [7:0] i_data,
   input wire logic [6:0] i_channel_request_pin,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_hold_request,
   output logic [1:0] o_byte_group_condition,
   output logic [1:0] o_word_group_condition
);
   function automatic logic [3:0] reg_index(input int g,
         input logic [4:0] xa);
      reg_index = (g == WORD_GROUP) ? xa[4:1] : xa[3:0];
   endfunction

   function automatic logic [15:0] put_byte(input logic [15:0] old,
         input logic hi, input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   logic [SYNC_W-1:0] sync_q;
   logic rd_n;
   logic wr_n;
   logic [1:0] sel;
   logic hold;
   logic [4:0] xa;
   logic [7:0] din;
   logic [6:0] req_pin;

   // Strobes, address and data all take the same two-stage path, so they
   // stay aligned with each other
   pin_sync #(.W(SYNC_W)) u_sync (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_async({i_io_read_strobe_n, i_io_write_strobe_n, i_group_sel,
         i_hold_ack, i_register_select_lines, i_data,
         i_channel_request_pin}),
      .o_sync(sync_q)
   );
   assign {rd_n, wr_n, sel, hold, xa, din, req_pin} = sync_q;

   // Access capture: the values seen while a strobe was low
   logic rd_prev_n;
   logic wr_prev_n;
   logic [1:0] sel_prev;
   logic [4:0] xa_prev;
   logic [7:0] din_prev;
   logic rd_end;
   logic wr_end;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         rd_prev_n <= 1'b1;
         wr_prev_n <= 1'b1;
         sel_prev <= 2'h0;
         xa_prev <= 5'h00;
         din_prev <= 8'h00;
      end else begin
         rd_prev_n <= rd_n;
         wr_prev_n <= wr_n;
         sel_prev <= sel;
         xa_prev <= xa;
         din_prev <= din;
      end
   end

   // Side effects act on the trailing edge, when write data is settled
   assign rd_end = rd_n && !rd_prev_n && !hold;
   assign wr_end = wr_n && !wr_prev_n && !hold;

   // Register file
   logic [15:0] base_addr [GROUPS][CHANS];
   logic [15:0] cur_addr [GROUPS][CHANS];
   logic [15:0] base_cnt [GROUPS][CHANS];
   logic [15:0] cur_cnt [GROUPS][CHANS];
   logic [5:0] mode [GROUPS][CHANS];
   logic [7:0] command [GROUPS];
   logic [3:0] mask [GROUPS];
   logic [3:0] swreq [GROUPS];
   logic [1:0] mode_cnt [GROUPS];
   logic ptr [GROUPS];
   logic [15:0] next_base_addr [GROUPS][CHANS];
   logic [15:0] next_cur_addr [GROUPS][CHANS];
   logic [15:0] next_base_cnt [GROUPS][CHANS];
   logic [15:0] next_cur_cnt [GROUPS][CHANS];
   logic [5:0] next_mode [GROUPS][CHANS];
   logic [7:0] next_command [GROUPS];
   logic [3:0] next_mask [GROUPS];
   logic [3:0] next_swreq [GROUPS];
   logic [1:0] next_mode_cnt [GROUPS];
   logic next_ptr [GROUPS];
   logic [3:0] chan_req [GROUPS];

   dma_cond_if cif [GROUPS] ();

   assign chan_req[BYTE_GROUP] = req_pin[3:0];
   // Channel 0 of the word group serves only the cascade
   assign chan_req[WORD_GROUP] = {req_pin[6:4],
      cif[BYTE_GROUP].cond == COND_ACTIVE};

   for (genvar gv = 0; gv < GROUPS; gv++) begin : g_grp
      assign cif[gv].cpu_access = sel[gv] && !hold && !(rd_n && wr_n);
      assign cif[gv].request = |((chan_req[gv] | swreq[gv]) & ~mask[gv]);
      assign cif[gv].enabled = !command[gv][CMD_DISABLE_BIT];
      dma_condition_tracker u_trk (
         .i_mclk(i_mclk),
         .i_nrst(i_nrst),
         .bus(cif[gv].tracker)
      );
   end

   always_comb begin
      logic [3:0] idx;
      logic [1:0] ch;
      logic [1:0] dch;
      idx = 4'h0;
      ch = 2'h0;
      dch = din_prev[1:0];
      next_base_addr = base_addr;
      next_cur_addr = cur_addr;
      next_base_cnt = base_cnt;
      next_cur_cnt = cur_cnt;
      next_mode = mode;
      next_command = command;
      next_mask = mask;
      next_swreq = swreq;
      next_mode_cnt = mode_cnt;
      next_ptr = ptr;
      for (int g = 0; g < GROUPS; g++) begin
         idx = reg_index(g, xa_prev);
         ch = idx[2:1];
         if (wr_end && sel_prev[g]) begin
            if (!idx[3]) begin
               if (!idx[0]) begin
                  next_base_addr[g][ch] =
                     put_byte(base_addr[g][ch], ptr[g], din_prev);
                  next_cur_addr[g][ch] =
                     put_byte(cur_addr[g][ch], ptr[g], din_prev);
               end else begin
                  next_base_cnt[g][ch] =
                     put_byte(base_cnt[g][ch], ptr[g], din_prev);
                  next_cur_cnt[g][ch] =
                     put_byte(cur_cnt[g][ch], ptr[g], din_prev);
               end
               next_ptr[g] = !ptr[g];
            end else if (idx == IDX_STATUS) begin
               next_command[g] = din_prev;
            end else if (idx == IDX_REQUEST) begin
               next_swreq[g][dch] = din_prev[2];
            end else if (idx == IDX_SINGLE_MASK) begin
               next_mask[g][dch] = din_prev[2];
            end else if (idx == IDX_MODE) begin
               next_mode[g][dch] = din_prev[7:2];
            end else if (idx == IDX_POINTER) begin
               next_ptr[g] = 1'b0;
            end else if (idx == IDX_TEMP_CLEAR) begin
               // Master clear leaves every channel masked
               next_command[g] = COMMAND_RESET;
               next_swreq[g] = SWREQ_RESET;
               next_mask[g] = MASK_RESET;
               next_mode_cnt[g] = MODE_CNT_RESET;
               next_ptr[g] = POINTER_RESET;
            end else if (idx == IDX_CLEAR_MASK) begin
               next_mask[g] = 4'h0;
            end else begin
               next_mask[g] = din_prev[3:0];
            end
         end
         if (rd_end && sel_prev[g]) begin
            if (!idx[3]) begin
               next_ptr[g] = !ptr[g];
            end else if (idx == IDX_MODE) begin
               next_mode_cnt[g] = mode_cnt[g] + 2'h1;
            end else if (idx == IDX_POINTER) begin
               next_ptr[g] = 1'b1;
            end else if (idx == IDX_CLEAR_MASK) begin
               next_mode_cnt[g] = MODE_CNT_RESET;
            end
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         for (int g = 0; g < GROUPS; g++) begin
            for (int c = 0; c < CHANS; c++) begin
               base_addr[g][c] <= WORD_RESET;
               cur_addr[g][c] <= WORD_RESET;
               base_cnt[g][c] <= WORD_RESET;
               cur_cnt[g][c] <= WORD_RESET;
               mode[g][c] <= MODE_RESET;
            end
            command[g] <= COMMAND_RESET;
            mask[g] <= MASK_RESET;
            swreq[g] <= SWREQ_RESET;
            mode_cnt[g] <= MODE_CNT_RESET;
            ptr[g] <= POINTER_RESET;
         end
      end else begin
         base_addr <= next_base_addr;
         cur_addr <= next_cur_addr;
         base_cnt <= next_base_cnt;
         cur_cnt <= next_cur_cnt;
         mode <= next_mode;
         command <= next_command;
         mask <= next_mask;
         swreq <= next_swreq;
         mode_cnt <= next_mode_cnt;
         ptr <= next_ptr;
      end
   end

   // Read path and outputs
   logic [7:0] next_o_data;
   logic next_o_data_oe;
   logic next_o_hold_request;

   always_comb begin
      logic [3:0] idx;
      logic [1:0] ch;
      idx = 4'h0;
      ch = 2'h0;
      next_o_data = 8'h00;
      next_o_data_oe = 1'b0;
      for (int g = 0; g < GROUPS; g++) begin
         if (!rd_n && sel[g] && !hold) begin
            idx = reg_index(g, xa);
            ch = idx[2:1];
            next_o_data_oe = 1'b1;
            if (!idx[3]) begin
               if (!idx[0]) begin
                  next_o_data = ptr[g] ? cur_addr[g][ch][15:8]
                     : cur_addr[g][ch][7:0];
               end else begin
                  next_o_data = ptr[g] ? cur_cnt[g][ch][15:8]
                     : cur_cnt[g][ch][7:0];
               end
            end else if (idx == IDX_STATUS) begin
               // No transfers run here, so terminal count bits stay clear
               next_o_data = {chan_req[g], 4'h0};
            end else if (idx == IDX_REQUEST) begin
               next_o_data = {4'h0, swreq[g]};
            end else if (idx == IDX_SINGLE_MASK) begin
               next_o_data = command[g];
            end else if (idx == IDX_MODE) begin
               next_o_data = {mode[g][mode_cnt[g]], mode_cnt[g]};
            end else if (idx == IDX_TEMP_CLEAR) begin
               next_o_data = TEMP_VALUE;
            end else if (idx == IDX_ALL_MASK) begin
               next_o_data = {4'h0, mask[g]};
            end else begin
               next_o_data = 8'h00;
            end
         end
      end
      // Hold is asked for only from the active condition
      next_o_hold_request = cif[WORD_GROUP].cond == COND_ACTIVE;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
         o_hold_request <= 1'b0;
         o_byte_group_condition <= COND_IDLE;
         o_word_group_condition <= COND_IDLE;
      end else begin
         o_data <= next_o_data;
         o_data_oe <= next_o_data_oe;
         o_hold_request <= next_o_hold_request;
         o_byte_group_condition <= cif[BYTE_GROUP].cond;
         o_word_group_condition <= cif[WORD_GROUP].cond;
      end
   end
endmodule // cascaded_dma_register_front

/* File: sim/cascaded_dma_register_front_asserts.sv */
// Port assertions for the cascaded DMA register front
`timescale 1ns/1ps
module cascaded_dma_register_front_asserts
   import dma_front_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_io_read_strobe_n,
   input wire logic i_io_write_strobe_n,
   input wire logic [1:0] i_group_sel,
   input wire logic i_hold_ack,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe,
   input wire logic o_hold_request,
   input wire logic [1:0] o_byte_group_condition,
   input wire logic [1:0] o_word_group_condition
);
   default clocking dflt @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);
   sequence rd_start;
      $fell(i_io_read_strobe_n) && i_group_sel != 2'h0 && !i_hold_ack;
   endsequence
   // An active group keeps the bus, so only writes begun in idle count
   sequence wr_start_byte;
      $fell(i_io_write_strobe_n) && i_group_sel[0] && !i_hold_ack
         && o_byte_group_condition == 2'h0;
   endsequence
   sequence wr_start_word;
      $fell(i_io_write_strobe_n) && i_group_sel[1] && !i_hold_ack
         && o_word_group_condition == 2'h0;
   endsequence
   dout_quiet_a: assert property (!o_data_oe |-> o_data == 8'h00)
      else $error("read data present while output disabled");
   read_answer_a: assert property (rd_start |-> ##[2:4] o_data_oe)
      else $error("read data not driven after read strobe");
   read_release_a: assert property
      ($rose(i_io_read_strobe_n) |-> ##[3:4] !o_data_oe)
      else $error("read data still driven after strobe release");
   oe_idle_a: assert property (i_io_read_strobe_n[*6] |-> !o_data_oe)
      else $error("read data driven with no read");
   prog_byte_a: assert property
      (wr_start_byte |-> ##[2:4] o_byte_group_condition == 2'h1)
      else $error("byte group missed program condition");
   prog_word_a: assert property
      (wr_start_word |-> ##[2:4] o_word_group_condition == 2'h1)
      else $error("word group missed program condition");
   hold_block_a: assert property (i_hold_ack[*4] |->
      o_byte_group_condition != 2'h1 && o_word_group_condition != 2'h1)
      else $error("program condition entered while bus granted");
   hold_follow_a: assert property
      ((o_word_group_condition == 2'h2)[*2] |-> o_hold_request)
      else $error("hold request missing in active condition");
   hold_cause_a: assert property (o_hold_request |->
      o_word_group_condition == 2'h2 || $past(o_word_group_condition) == 2'h2)
      else $error("hold request outside active condition");
endmodule // cascaded_dma_register_front_asserts
bind cascaded_dma_register_front cascaded_dma_register_front_asserts
   i_cascaded_dma_register_front_asserts (.i_mclk, .i_nrst,
   .i_io_read_strobe_n, .i_io_write_strobe_n, .i_group_sel, .i_hold_ack,
   .o_data, .o_data_oe, .o_hold_request, .o_byte_group_condition,
   .o_word_group_condition);

/* File: sim/host_cpu_model.sv */
// Host CPU model making I/O reads and writes on the register front
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic i_mclk,
   input wire logic [7:0] i_data,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic [1:0] o_sel,
   output logic [4:0] o_xa,
   output logic [7:0] o_data
);
   initial begin
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_sel = 2'h0;
      o_xa = 5'h00;
      o_data = 8'h00;
   end
   // Strobe low 4 cycles, high at least 5: margin over the synchroniser
   task automatic access(input logic wr, input logic [1:0] sel,
      input logic [4:0] xa, input logic [7:0] d, output logic [7:0] q);
      @(negedge i_mclk);
      o_sel = sel;
      o_xa = xa;
      o_data = d;
      o_wr_n = !wr;
      o_rd_n = wr;
      repeat (4) @(negedge i_mclk);
      q = i_data;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      // Address must outlive the synchronised strobe rise
      repeat (3) @(negedge i_mclk);
      o_sel = 2'h0;
      o_xa = ~xa;
      o_data = ~d;
      repeat (2) @(negedge i_mclk);
   endtask
endmodule // host_cpu_model

/* File: sim/cascaded_dma_register_front_tb.sv */
// Self-checking bench for the cascaded DMA register front
`timescale 1ns/1ps
module cascaded_dma_register_front_tb;
   import dma_front_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic hold_ack = 1'b0;
   logic [6:0] req_pin = 7'h00;
   logic rd_n;
   logic wr_n;
   logic [1:0] sel;
   logic [4:0] xa;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic data_oe;
   logic hold_req;
   logic [1:0] byte_cond;
   logic [1:0] word_cond;
   int failures = 0;
   int checks_done = 0;
   always #12.5 mclk = ~mclk;
   cascaded_dma_register_front i_cascaded_dma_register_front (
      .i_mclk(mclk), .i_nrst(nrst), .i_io_read_strobe_n(rd_n),
      .i_io_write_strobe_n(wr_n), .i_group_sel(sel), .i_hold_ack(hold_ack),
      .i_register_select_lines(xa), .i_data(wdata),
      .i_channel_request_pin(req_pin), .o_data(rdata), .o_data_oe(data_oe),
      .o_hold_request(hold_req), .o_byte_group_condition(byte_cond),
      .o_word_group_condition(word_cond));
   host_cpu_model i_host_cpu_model (.i_mclk(mclk), .i_data(rdata),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel(sel), .o_xa(xa), .o_data(wdata));
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Word group gets bit 0 set, which its decode must ignore
   function automatic logic [4:0] xa_of(input int g, input logic [3:0] idx);
      return (g == WORD_GROUP) ? {idx, 1'b1} : {1'b0, idx};
   endfunction
   task automatic wr(input int g, input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] q;
      i_host_cpu_model.access(1'b1, 2'(1 << g), xa_of(g, idx), d, q);
   endtask
   task automatic rd(input int g, input logic [3:0] idx, output logic [7:0] q);
      i_host_cpu_model.access(1'b0, 2'(1 << g), xa_of(g, idx), 8'h00, q);
   endtask
   task automatic rdc(input int g, input logic [3:0] idx, input logic [7:0] e);
      logic [7:0] q;
      rd(g, idx, q);
      check(q, e);
   endtask
   task automatic t_reset_vals;
      for (int g = 0; g < GROUPS; g++) begin
         rdc(g, IDX_ALL_MASK, {4'h0, MASK_RESET});
         rdc(g, IDX_SINGLE_MASK, COMMAND_RESET);
      end
   endtask
   task automatic t_conditions;
      req_pin = 7'h02;
      repeat (8) @(negedge mclk);
      check({6'h0, byte_cond}, {6'h0, COND_IDLE});
      // Cascade channel of the word group starts masked like the rest
      wr(WORD_GROUP, IDX_CLEAR_MASK, 8'h00);
      wr(BYTE_GROUP, IDX_CLEAR_MASK, 8'h00);
      repeat (6) @(negedge mclk);
      check({6'h0, byte_cond}, {6'h0, COND_ACTIVE});
      check({6'h0, word_cond}, {6'h0, COND_ACTIVE});
      check({7'h0, hold_req}, 8'h01);
      wr(BYTE_GROUP, IDX_STATUS, 8'h04);
      repeat (6) @(negedge mclk);
      check({6'h0, byte_cond}, {6'h0, COND_IDLE});
      check({7'h0, hold_req}, 8'h00);
      wr(BYTE_GROUP, IDX_STATUS, 8'h00);
      req_pin = 7'h10;
      wr(WORD_GROUP, IDX_CLEAR_MASK, 8'h00);
      repeat (6) @(negedge mclk);
      check({6'h0, word_cond}, {6'h0, COND_ACTIVE});
      req_pin = 7'h00;
      repeat (8) @(negedge mclk);
      check({6'h0, word_cond}, {6'h0, COND_IDLE});
      check({7'h0, hold_req}, 8'h00);
   endtask
   task automatic t_pairing;
      logic [7:0] q;
      for (int g = 0; g < GROUPS; g++) begin
         wr(g, IDX_POINTER, 8'h00);
         wr(g, 4'h2, 8'h34);
         wr(g, 4'h2, 8'(8'h12 + g));
         wr(g, 4'h3, 8'h78);
         wr(g, 4'h3, 8'h56);
         rdc(g, 4'h2, 8'h34);
         rdc(g, 4'h2, 8'(8'h12 + g));
         rdc(g, 4'h3, 8'h78);
         rdc(g, 4'h3, 8'h56);
      end
      // Pointer read leaves it set; master clear or a pointer port write restores low-byte order
      rd(BYTE_GROUP, IDX_POINTER, q);
      wr(BYTE_GROUP, IDX_TEMP_CLEAR, 8'h00);
      wr(BYTE_GROUP, 4'h6, 8'h9a);
      rd(BYTE_GROUP, IDX_POINTER, q);
      wr(BYTE_GROUP, 4'h6, 8'hde);
      wr(BYTE_GROUP, IDX_POINTER, 8'h00);
      rdc(BYTE_GROUP, 4'h6, 8'h9a);
      rdc(BYTE_GROUP, 4'h6, 8'hde);
   endtask
   task automatic t_masks;
      wr(BYTE_GROUP, IDX_ALL_MASK, 8'h05);
      rdc(BYTE_GROUP, IDX_ALL_MASK, 8'h05);
      wr(BYTE_GROUP, IDX_SINGLE_MASK, 8'h02);
      rdc(BYTE_GROUP, IDX_ALL_MASK, 8'h01);
      wr(BYTE_GROUP, IDX_SINGLE_MASK, 8'h07);
      rdc(BYTE_GROUP, IDX_ALL_MASK, 8'h09);
      wr(BYTE_GROUP, IDX_CLEAR_MASK, 8'h00);
      rdc(BYTE_GROUP, IDX_ALL_MASK, 8'h00);
      wr(BYTE_GROUP, IDX_REQUEST, 8'h07);
      rdc(BYTE_GROUP, IDX_REQUEST, 8'h08);
      wr(BYTE_GROUP, IDX_REQUEST, 8'h03);
      rdc(BYTE_GROUP, IDX_REQUEST, 8'h00);
   endtask
   task automatic t_mode;
      logic [7:0] q;
      wr(WORD_GROUP, IDX_MODE, 8'ha4);
      wr(WORD_GROUP, IDX_STATUS, 8'h10);
      rd(WORD_GROUP, IDX_CLEAR_MASK, q);
      rdc(WORD_GROUP, IDX_MODE, 8'ha4);
      rdc(WORD_GROUP, IDX_MODE, 8'h01);
      rd(WORD_GROUP, IDX_CLEAR_MASK, q);
      rdc(WORD_GROUP, IDX_MODE, 8'ha4);
      rdc(WORD_GROUP, IDX_SINGLE_MASK, 8'h10);
      wr(WORD_GROUP, IDX_STATUS, 8'h00);
   endtask
   task automatic t_refuse;
      wr(BYTE_GROUP, IDX_ALL_MASK, 8'h03);
      hold_ack = 1'b1;
      repeat (4) @(negedge mclk);
      wr(BYTE_GROUP, IDX_ALL_MASK, 8'h0c);
      hold_ack = 1'b0;
      repeat (4) @(negedge mclk);
      rdc(BYTE_GROUP, IDX_ALL_MASK, 8'h03);
   endtask
   initial begin
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      t_reset_vals();
      t_conditions();
      t_pairing();
      t_masks();
      t_mode();
      t_refuse();
      close_out();
   end
   initial begin
      // The tests need about 640 cycles; 20000, some thirty times that, means a hang
      repeat (20000) @(posedge mclk);
      failures++;
      close_out();
   end
endmodule // cascaded_dma_register_front_tb
